//--- common/slpsd_map.vh
// Constants for the latched power sink driver: widths, reset values, timing counts.
// Assumes it is included by bare name from every design file that needs it.
`ifndef SLPSD_MAP_VH
`define SLPSD_MAP_VH

// ****************************************************************
// Structure
// ****************************************************************
`define SLPSD_WIDTH 8
`define SLPSD_PIN_COUNT 5

// ****************************************************************
// Reset values
// ****************************************************************
`define SLPSD_SHIFT_RST 8'h00
`define SLPSD_STORE_RST 8'h00
`define SLPSD_BUF_RST 8'h00
// Pin order {data, shift clk, storage clk, clear_n, enable_n}
`define SLPSD_PIN_RST 5'h03

// ****************************************************************
// Timing
// ****************************************************************
`define SLPSD_CLK_PERIOD_NS 50
`define SLPSD_LINK_PERIOD_NS 400
`define SLPSD_TW_NS 20
`define SLPSD_TW_RAW ((`SLPSD_TW_NS + `SLPSD_CLK_PERIOD_NS - 1) / `SLPSD_CLK_PERIOD_NS)
`define SLPSD_TW_CYC ((`SLPSD_TW_RAW < 1) ? 1 : `SLPSD_TW_RAW)
`define SLPSD_LINK_CYC (`SLPSD_LINK_PERIOD_NS / `SLPSD_CLK_PERIOD_NS)

`endif

//--- design/slpsd_sync.v
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level from outside the clk_sys domain.
`timescale 1ns/10ps

module slpsd_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_q
);

  // ****************************************************************
  // Metastability stages
  // ****************************************************************
  reg [WIDTH-1:0] meta_q;

  // First stage is read by the second stage only
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule // slpsd_sync

//--- design/slpsd_chan.v
// One open-drain sink channel: drives the enable from the buffer bit.
// Assumes the pad resolves the wire; drain_in is the pad level read back.
`timescale 1ns/10ps

module slpsd_chan (
  input wire clk_sys,
  input wire reset,
  input wire buf_bit,
  input wire drain_in,
  output reg drain_out,
  output reg drain_oe,
  output wire drain_level
);

  // ****************************************************************
  // Sink drive
  // ****************************************************************
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      drain_out <= 1'b0;
      drain_oe <= 1'b0;
    end
    else
    begin
      // Only ever pulls low; off means released
      drain_out <= 1'b0;
      drain_oe <= buf_bit;
    end
  end

  // ****************************************************************
  // Pad readback
  // ****************************************************************
  slpsd_sync #(
    .WIDTH(1),
    .RST_VAL(1'b1)
  ) u_level_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(drain_in),
    .sync_q(drain_level)
  );

endmodule // slpsd_chan

//--- design/slpsd_top.v
// Serial-in latched power sink driver: shift stages, storage register,
// gated output buffer and eight open-drain sink channels.
// Assumes all control pins are asynchronous to clk_sys and change slowly
// compared with it; the shift clock is sampled and its edges found here.
`timescale 1ns/10ps
`include "slpsd_map.vh"

module slpsd_top #(
  parameter WIDTH = `SLPSD_WIDTH
) (
  input wire clk_sys,
  input wire reset,
  input wire shift_data_in,
  input wire shift_clock_in,
  input wire storage_latch_clock,
  input wire shift_clear_n,
  input wire output_enable_n,
  input wire [WIDTH-1:0] drain_in,
  output wire [WIDTH-1:0] drain_out,
  output wire [WIDTH-1:0] drain_oe,
  output wire [WIDTH-1:0] drain_level,
  output reg cascade_out,
  output reg [WIDTH-1:0] shift_stages,
  output reg [WIDTH-1:0] storage_bits,
  output reg [WIDTH-1:0] output_buffer
);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  wire [`SLPSD_PIN_COUNT-1:0] pin_raw;
  wire [`SLPSD_PIN_COUNT-1:0] pin_sync;
  wire data_s;
  wire shift_clk_s;
  wire store_clk_s;
  wire clear_n_s;
  wire enable_n_s;

  assign pin_raw = {shift_data_in, shift_clock_in, storage_latch_clock,
                    shift_clear_n, output_enable_n};

  // Data and clocks share one delay, so data stays aligned to its clock
  slpsd_sync #(
    .WIDTH(`SLPSD_PIN_COUNT),
    .RST_VAL(`SLPSD_PIN_RST)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(pin_raw),
    .sync_q(pin_sync)
  );

  assign data_s = pin_sync[4];
  assign shift_clk_s = pin_sync[3];
  assign store_clk_s = pin_sync[2];
  assign clear_n_s = pin_sync[1];
  assign enable_n_s = pin_sync[0];

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  reg shift_clk_q;
  reg store_clk_q;
  wire shift_rise;
  wire store_rise;

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      shift_clk_q <= 1'b0;
      store_clk_q <= 1'b0;
    end
    else
    begin
      shift_clk_q <= shift_clk_s;
      store_clk_q <= store_clk_s;
    end
  end

  assign shift_rise = shift_clk_s & ~shift_clk_q;
  assign store_rise = store_clk_s & ~store_clk_q;

  // ****************************************************************
  // Shift stages
  // ****************************************************************
  reg [WIDTH-1:0] shift_d;

  always @*
  begin
    shift_d = shift_stages;
    if (!clear_n_s)
    begin
      // Clear is a level and beats any shift edge
      shift_d = `SLPSD_SHIFT_RST;
    end
    else if (shift_rise)
    begin
      shift_d = {shift_stages[WIDTH-2:0], data_s};
    end
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      shift_stages <= `SLPSD_SHIFT_RST;
      cascade_out <= 1'b0;
    end
    else
    begin
      shift_stages <= shift_d;
      cascade_out <= shift_d[WIDTH-1];
    end
  end

  // ****************************************************************
  // Storage register
  // ****************************************************************
  reg [WIDTH-1:0] storage_d;

  // Same-cycle shift and store edges store the pre-shift stages
  always @*
  begin
    storage_d = storage_bits;
    if (store_rise)
    begin
      storage_d = shift_stages;
    end
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      storage_bits <= `SLPSD_STORE_RST;
    end
    else
    begin
      storage_bits <= storage_d;
    end
  end

  // ****************************************************************
  // Output buffer
  // ****************************************************************
  reg [WIDTH-1:0] buffer_d;

  always @*
  begin
    buffer_d = output_buffer;
    if (enable_n_s)
    begin
      buffer_d = `SLPSD_BUF_RST;
    end
    else if (clear_n_s)
    begin
      // Transparent apart from the register stage for the pins
      buffer_d = storage_bits;
    end
  end

  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      output_buffer <= `SLPSD_BUF_RST;
    end
    else
    begin
      output_buffer <= buffer_d;
    end
  end

  // ****************************************************************
  // Sink channels
  // ****************************************************************
  genvar ch;

  generate
    for (ch = 0; ch < WIDTH; ch = ch + 1)
    begin : g_chan
      slpsd_chan u_chan (
        .clk_sys(clk_sys),
        .reset(reset),
        .buf_bit(output_buffer[ch]),
        .drain_in(drain_in[ch]),
        .drain_out(drain_out[ch]),
        .drain_oe(drain_oe[ch]),
        .drain_level(drain_level[ch])
      );
    end
  endgenerate

endmodule // slpsd_top

//--- bench/slpsd_host_model.sv
// Host model: shifts bytes farthest bit first, then pulses the storage clock.
// Assumes tb_top calls send and that link edges are 200 ns apart.
`timescale 1ns/10ps
module slpsd_host_model (
  input wire clk_sys,
  output logic shift_data_in,
  output logic shift_clock_in,
  output logic storage_latch_clock
);
  // ********
  // Link
  // ********
  initial
  begin
    shift_data_in = 1'h0;
    shift_clock_in = 1'h0;
    storage_latch_clock = 1'h0;
  end
  task automatic half;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic send(input logic [7:0] b, input logic latch);
    integer i;
    for (i = 7; i >= 0; i--)
    begin
      shift_data_in = b[i];
      half();
      shift_clock_in = 1'h1;
      half();
      shift_clock_in = 1'h0;
    end
    // Stale data must not look valid after the frame
    shift_data_in = ~b[0];
    if (latch)
    begin
      half();
      storage_latch_clock = 1'h1;
      half();
      storage_latch_clock = 1'h0;
    end
  endtask
endmodule // slpsd_host_model

//--- bench/slpsd_top_sva.sv
// Checker for the sink driver: stages, storage, buffer and drains.
// Assumes the two-flop pin sync delays of the top module.
`timescale 1ns/10ps
module slpsd_top_sva #(parameter WIDTH = 8) (
  input wire clk_sys,
  input wire reset,
  input wire shift_data_in,
  input wire shift_clock_in,
  input wire storage_latch_clock,
  input wire shift_clear_n,
  input wire output_enable_n,
  input wire [WIDTH-1:0] drain_in,
  input wire [WIDTH-1:0] drain_out,
  input wire [WIDTH-1:0] drain_oe,
  input wire [WIDTH-1:0] drain_level,
  input wire cascade_out,
  input wire [WIDTH-1:0] shift_stages,
  input wire [WIDTH-1:0] storage_bits,
  input wire [WIDTH-1:0] output_buffer
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Repeats are generous so a pin caught mid-sync cannot fire a check
  sequence s_shift_rise;
    (shift_clear_n && !shift_clock_in)[*2] ##1 (shift_clear_n && shift_clock_in)[*3];
  endsequence
  sequence s_store_rise;
    !storage_latch_clock[*2] ##1 storage_latch_clock[*3];
  endsequence
  // Stages move at the edge that ends the rise, so they are seen one sample later
  a_shift_step: assert property (s_shift_rise |=>
    shift_stages == {$past(shift_stages[WIDTH-2:0]), $past(shift_data_in, 3)})
    else $error("shift step wrong");
  a_store_take: assert property (s_store_rise |=> storage_bits == $past(shift_stages))
    else $error("storage capture wrong");
  a_clear_zero: assert property (!shift_clear_n[*4] |-> shift_stages == '0)
    else $error("stages not cleared");
  a_cascade_last: assert property (cascade_out == shift_stages[WIDTH-1])
    else $error("cascade not last stage");
  a_sink_map: assert property (drain_oe == $past(output_buffer) && drain_out == '0)
    else $error("sink enable wrong");
  // Drains lag the buffer by one more stage
  a_enable_off: assert property (output_enable_n[*5] |-> output_buffer == '0 && drain_oe == '0)
    else $error("outputs not off");
  a_buf_follow: assert property ((!output_enable_n && shift_clear_n)[*4] |->
    output_buffer == $past(storage_bits)) else $error("buffer not following");
  a_buf_hold: assert property ((!output_enable_n && !shift_clear_n)[*4] |->
    $stable(output_buffer)) else $error("buffer loaded under clear");
endmodule // slpsd_top_sva
bind slpsd_top slpsd_top_sva #(.WIDTH(WIDTH)) chk (.clk_sys(clk_sys), .reset(reset),
  .shift_data_in(shift_data_in), .shift_clock_in(shift_clock_in),
  .storage_latch_clock(storage_latch_clock), .shift_clear_n(shift_clear_n),
  .output_enable_n(output_enable_n), .drain_in(drain_in), .drain_out(drain_out),
  .drain_oe(drain_oe), .drain_level(drain_level), .cascade_out(cascade_out),
  .shift_stages(shift_stages), .storage_bits(storage_bits), .output_buffer(output_buffer));

//--- bench/tb_top.sv
// Bench for the sink driver: random and corner bytes, enable and clear.
// Assumes the host model drives the link pins at falling edges.
`timescale 1ns/10ps
`include "slpsd_map.vh"
module tb_top;
  // ********
  // Bench
  // ********
  logic clk_sys, reset, shift_clear_n, output_enable_n;
  wire shift_data_in, shift_clock_in, storage_latch_clock, cascade_out;
  wire [7:0] drain_out, drain_oe, drain_level, shift_stages, storage_bits, output_buffer;
  wire [7:0] drain_in;
  integer num_errors, checked, i;
  logic [31:0] seed;
  logic [7:0] b;
  logic [23:0] corner;
  // Pull-up holds each wire high unless its sink is on
  assign drain_in = ~drain_oe;
  slpsd_host_model host (.clk_sys(clk_sys), .shift_data_in(shift_data_in),
    .shift_clock_in(shift_clock_in), .storage_latch_clock(storage_latch_clock));
  slpsd_top uut (.clk_sys(clk_sys), .reset(reset), .shift_data_in(shift_data_in),
    .shift_clock_in(shift_clock_in), .storage_latch_clock(storage_latch_clock),
    .shift_clear_n(shift_clear_n), .output_enable_n(output_enable_n), .drain_in(drain_in),
    .drain_out(drain_out), .drain_oe(drain_oe), .drain_level(drain_level),
    .cascade_out(cascade_out), .shift_stages(shift_stages), .storage_bits(storage_bits),
    .output_buffer(output_buffer));
  initial
  begin
    clk_sys = 1'h0;
    forever #(`SLPSD_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic logic [7:0] exp_out(input logic [7:0] d, input logic en_n);
    exp_out = en_n ? 8'h00 : d;
  endfunction
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic settle;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic frame(input logic [7:0] v);
    host.send(v, 1'h1);
    settle();
    check("shift_stages", v, shift_stages);
    check("cascade_out", {7'h00, v[7]}, {7'h00, cascade_out});
    check("storage_bits", v, storage_bits);
    check("output_buffer", exp_out(v, output_enable_n), output_buffer);
    check("drain_oe", exp_out(v, output_enable_n), drain_oe);
    check("drain_out", 8'h00, drain_out);
    check("drain_level", ~exp_out(v, output_enable_n), drain_level);
  endtask
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end
  initial
  begin
    reset = 1'h1;
    shift_clear_n = 1'h1;
    output_enable_n = 1'h0;
    num_errors = 0;
    checked = 0;
    seed = 32'h00004C88;
    repeat (5) @(negedge clk_sys);
    reset = 1'h0;
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      corner = 24'h80FF01 >> (8 * i);
      b = (i < 3) ? corner[7:0] : seed[7:0];
      frame(b);
    end
    frame(8'hC3);
    output_enable_n = 1'h1;
    settle();
    check("output_buffer", exp_out(8'hC3, 1'h1), output_buffer);
    check("drain_oe", 8'h00, drain_oe);
    output_enable_n = 1'h0;
    settle();
    check("output_buffer", exp_out(8'hC3, 1'h0), output_buffer);
    shift_clear_n = 1'h0;
    settle();
    check("shift_stages", 8'h00, shift_stages);
    host.send(8'h5A, 1'h1);
    settle();
    check("shift_stages", 8'h00, shift_stages);
    check("storage_bits", 8'h00, storage_bits);
    check("output_buffer", 8'hC3, output_buffer);
    shift_clear_n = 1'h1;
    settle();
    check("output_buffer", 8'h00, output_buffer);
    end_of_test();
  end
endmodule // tb_top
